// file: rtl/tcwd_pkg.sv
// Shared constants and types for the touch wheel detect and compensation block.
// Assumes a single 200 MHz clock and a tick converter that reports signed ticks.
package tcwd_pkg;

  // Sizes of the sensing array and of its data words.
  localparam int IN_NUM = 12;
  localparam int IDX_W = 4;
  localparam int TICK_W = 16;
  localparam int COMP_W = 16;
  localparam int SENS_W = 4;
  localparam int POS_W = 8;
  localparam int DIV_W = 32;
  localparam int AVG_SHIFT = 3;

  // Scan period timing, derived from the clock rate.
  localparam int CLK_MHZ = 200;
  localparam int SCAN_PERIOD_US = 30000;
  localparam int SCAN_CYC_DEF = SCAN_PERIOD_US * CLK_MHZ;

  // Reset and start values.
  localparam logic [COMP_W-1:0] COMP_RST = 16'h0000;
  localparam logic [COMP_W-1:0] COMP_MSB = 16'h8000;
  localparam logic [TICK_W-1:0] TICK_RST = 16'h0000;
  localparam logic [15:0] PER_RST = 16'h0000;
  localparam logic [POS_W-1:0] POS_RST = 8'h00;
  localparam logic [IDX_W-1:0] BIT_TOP = 4'hF;

  // Sequencer states.
  typedef enum logic [3:0] {
    ST_IDLE, ST_FIND, ST_READ, ST_CONV, ST_WAIT, ST_ACC, ST_DSET, ST_DIV, ST_DONE
  } tcwd_state_e;

endpackage : tcwd_pkg

// file: rtl/tcwd_mem_if.sv
// Carrier between the sequencer and the compensation value store.
// Assumes one clock shared by both ends; read data lag the address by one edge.
`timescale 1ns/1ps
interface tcwd_mem_if #(
  parameter int AW = 4,
  parameter int DW = 16
);
  logic we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;

  modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : tcwd_mem_if

// file: rtl/tcwd_mem.sv
// Small word store holding one offset compensation value per sense input.
// The controller reads and writes the same word in one cycle; that read returns the old contents.
`timescale 1ns/1ps
module tcwd_mem #(
  parameter int DEPTH = 12
) (
  // Clock.
  input wire logic clk_i,
  // Access port.
  tcwd_mem_if.mem port
);

  logic [$bits(port.wdata)-1:0] store [DEPTH];
  logic [$bits(port.wdata)-1:0] rdata_ff;

  // Contents carry no reset: they are rebuilt after every power-up.
  always_ff @(posedge clk_i) begin
    if (port.we) begin
      store[port.waddr] <= port.wdata;
    end
    rdata_ff <= store[port.raddr];
  end

  assign port.rdata = rdata_ff;

endmodule : tcwd_mem

// file: rtl/tcwd_top.sv
// Scan sequencer, touch detection, wheel position and offset compensation.
// Assumes a tick converter that takes a start pulse and returns signed ticks with a done pulse.
`timescale 1ns/1ps
module tcwd_top import tcwd_pkg::*; #(
  parameter int N_IN = IN_NUM,
  parameter int SCAN_CYC = SCAN_CYC_DEF
) (
  // Clock and reset.
  input wire logic MCLK_I,
  input wire logic RESETN_I,
  // Mode and host control.
  input wire logic RUN_I,
  input wire logic COMP_REQ_I,
  // Configuration.
  input wire logic [N_IN-1:0] EN_I,
  input wire logic [N_IN-1:0] WHEEL_I,
  input wire logic [N_IN*TICK_W-1:0] THRESH_I,
  input wire logic [TICK_W-1:0] HYST_I,
  input wire logic [N_IN*SENS_W-1:0] SENS_I,
  input wire logic [POS_W-1:0] WHL_MAX_I,
  input wire logic [POS_W-1:0] STEP_I,
  input wire logic [TICK_W-1:0] NOISE_POS_I,
  input wire logic [TICK_W-1:0] NOISE_NEG_I,
  input wire logic [15:0] COMP_PERIOD_I,
  // Analog tick converter.
  output logic CONV_START_O,
  output logic [IDX_W-1:0] CONV_SEL_O,
  output logic [SENS_W-1:0] CONV_SENS_O,
  output logic [COMP_W-1:0] CONV_COMP_O,
  input wire logic CONV_DONE_I,
  input wire logic [TICK_W-1:0] CONV_TICKS_I,
  // Detection results.
  output logic [N_IN-1:0] BTN_ON_O,
  output logic WHL_ON_O,
  output logic [POS_W-1:0] WHL_POS_O,
  output logic ROT_CW_O,
  output logic ROT_CCW_O,
  output logic COMP_BUSY_O,
  output logic SCAN_DONE_O
);

  // The index counter must be able to hold N_IN itself as the end marker.
  if (N_IN < 2 || N_IN > 15) begin : g_bad_n
    $error("N_IN must lie between 2 and 15");
  end
  if (SCAN_CYC < 64) begin : g_bad_scan
    $error("SCAN_CYC too short for one scan");
  end

  localparam logic [IDX_W-1:0] N_IDX = IDX_W'(N_IN);
  localparam logic [31:0] SCAN_LAST = 32'(SCAN_CYC - 1);

  // Hysteresis decision for one input, shared by buttons, proximity and wheel members.
  function automatic logic on_next(input logic on, input logic [TICK_W-1:0] t,
                                   input logic [TICK_W-1:0] thr,
                                   input logic [TICK_W-1:0] hy);
    logic signed [TICK_W+1:0] ts;
    logic signed [TICK_W+1:0] hi;
    logic signed [TICK_W+1:0] lo;
    ts = {{2{t[TICK_W-1]}}, t};
    hi = $signed({2'b00, thr}) + $signed({2'b00, hy});
    lo = $signed({2'b00, thr}) - $signed({2'b00, hy});
    on_next = on ? !(ts < lo) : (ts >= hi);
  endfunction : on_next

  tcwd_state_e state_ff;
  logic [IDX_W-1:0] idx_ff;
  logic [IDX_W-1:0] bit_ff;
  logic [IDX_W-1:0] k_ff;
  logic [COMP_W-1:0] trial_ff;
  logic [SENS_W-1:0] sens_ff;
  logic start_ff;
  logic comp_ff;
  logic pend_ff;
  logic [31:0] scan_cnt_ff;
  logic [15:0] per_cnt_ff;
  logic [TICK_W-1:0] ticks_ff [N_IN];
  logic [TICK_W-1:0] avg_ff [N_IN];
  logic [N_IN-1:0] on_ff;
  logic [23:0] wsum_ff;
  logic [23:0] psum_ff;
  logic [DIV_W-1:0] quo_ff;
  logic [DIV_W:0] rem_ff;
  logic [DIV_W-1:0] den_ff;
  logic [4:0] div_cnt_ff;
  logic [POS_W-1:0] pos_ff;
  logic [POS_W-1:0] prev_ff;
  logic prev_vld_ff;
  logic whl_on_ff;
  logic cw_ff;
  logic ccw_ff;
  logic done_ff;
  logic [N_IN-1:0] btn_ff;

  tcwd_mem_if #(.AW(IDX_W), .DW(COMP_W)) mif ();

  tcwd_mem #(.DEPTH(N_IN)) u_mem (
    .clk_i(MCLK_I),
    .port(mif.mem)
  );

  // Selection of the current input, guarded against the end-marker index.
  wire in_range = idx_ff < N_IDX;
  wire [IDX_W-1:0] sidx = in_range ? idx_ff : '0;
  wire cur_en = in_range && EN_I[sidx];
  wire cur_whl = cur_en && WHEEL_I[sidx];
  wire [TICK_W-1:0] cur_tick = ticks_ff[sidx];
  wire [TICK_W-1:0] cur_thr = THRESH_I[sidx*TICK_W +: TICK_W];
  wire [SENS_W-1:0] cur_sens = SENS_I[sidx*SENS_W +: SENS_W];
  wire cur_pos = !cur_tick[TICK_W-1] && (cur_tick != TICK_RST);

  // Scan timer and the triggers that start a compensation run.
  wire scan_tick = scan_cnt_ff == SCAN_LAST;
  wire scan_take = (state_ff == ST_IDLE) && scan_tick && RUN_I;
  wire per_hit = (COMP_PERIOD_I != PER_RST) && (per_cnt_ff + 16'h0001 >= COMP_PERIOD_I);
  wire host_req = COMP_REQ_I && RUN_I;

  // Successive approximation step: larger compensation gives fewer ticks.
  wire [COMP_W-1:0] bit_mask = COMP_W'(1) << bit_ff;
  wire tick_hi = !CONV_TICKS_I[TICK_W-1] && (CONV_TICKS_I != TICK_RST);
  wire [COMP_W-1:0] trial_kept = tick_hi ? trial_ff : (trial_ff & ~bit_mask);
  wire last_bit = bit_ff == '0;

  // First-order low-pass of the raw ticks and its noise band check.
  wire [TICK_W:0] avg_diff = {CONV_TICKS_I[TICK_W-1], CONV_TICKS_I}
                           - {avg_ff[sidx][TICK_W-1], avg_ff[sidx]};
  wire [TICK_W:0] avg_step = $signed(avg_diff) >>> AVG_SHIFT;
  wire [TICK_W-1:0] avg_next = avg_ff[sidx] + avg_step[TICK_W-1:0];
  wire noise_out = ($signed(avg_next) > $signed({1'b0, NOISE_POS_I}))
                || ($signed({avg_next[TICK_W-1], avg_next})
                    < -$signed({1'b0, NOISE_NEG_I}));
  wire noise_hit = (state_ff == ST_WAIT) && CONV_DONE_I && !comp_ff && noise_out;

  // Restoring divider step for the centre of gravity quotient.
  wire [DIV_W:0] rem_sh = {rem_ff[DIV_W-1:0], quo_ff[DIV_W-1]};
  wire div_ge = rem_sh >= {1'b0, den_ff};
  wire [DIV_W:0] rem_nx = div_ge ? (rem_sh - {1'b0, den_ff}) : rem_sh;
  wire [POS_W-1:0] quo_pos = (quo_ff > DIV_W'(WHL_MAX_I)) ? WHL_MAX_I : quo_ff[POS_W-1:0];

  // Rotation step between the last and the new position.
  wire [POS_W:0] fwd = {1'b0, quo_pos} - {1'b0, prev_ff};
  wire [POS_W:0] bwd = {1'b0, prev_ff} - {1'b0, quo_pos};
  wire any_whl_on = |(on_ff & WHEEL_I & EN_I);

  // Scan period timer; runs freely so the period does not depend on the scan length.
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      scan_cnt_ff <= '0;
    end else begin
      scan_cnt_ff <= scan_tick ? '0 : scan_cnt_ff + 32'h0000_0001;
    end
  end

  // Pending compensation request; a new cause in the taking cycle is kept.
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      pend_ff <= 1'b1;
    end else begin
      pend_ff <= noise_hit || host_req || (state_ff == ST_DONE && per_hit)
              || (pend_ff && !scan_take);
    end
  end

  // Main sequencer: measure, compensate or process, then wait for the next period.
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      state_ff <= ST_IDLE;
      idx_ff <= '0;
      bit_ff <= BIT_TOP;
      trial_ff <= COMP_RST;
      sens_ff <= '0;
      start_ff <= 1'b0;
      comp_ff <= 1'b0;
      per_cnt_ff <= PER_RST;
    end else begin
      start_ff <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (scan_take) begin
            comp_ff <= pend_ff;
            idx_ff <= '0;
            state_ff <= ST_FIND;
          end
        end
        ST_FIND: begin
          if (!in_range) begin
            idx_ff <= '0;
            if (comp_ff) begin
              comp_ff <= 1'b0;
              per_cnt_ff <= PER_RST;
              state_ff <= ST_IDLE;
            end else begin
              state_ff <= ST_ACC;
            end
          end else if (cur_en) begin
            state_ff <= ST_READ;
          end else begin
            idx_ff <= idx_ff + 4'h1;
          end
        end
        ST_READ: begin
          trial_ff <= comp_ff ? COMP_MSB : mif.rdata;
          sens_ff <= cur_sens;
          bit_ff <= BIT_TOP;
          state_ff <= ST_CONV;
        end
        ST_CONV: begin
          start_ff <= 1'b1;
          state_ff <= ST_WAIT;
        end
        ST_WAIT: begin
          if (CONV_DONE_I) begin
            if (comp_ff && !last_bit) begin
              trial_ff <= trial_kept | (bit_mask >> 1);
              bit_ff <= bit_ff - 4'h1;
              state_ff <= ST_CONV;
            end else begin
              if (comp_ff) begin
                trial_ff <= trial_kept;
              end
              idx_ff <= idx_ff + 4'h1;
              state_ff <= ST_FIND;
            end
          end
        end
        ST_ACC: begin
          if (in_range) begin
            idx_ff <= idx_ff + 4'h1;
          end else begin
            state_ff <= ST_DSET;
          end
        end
        ST_DSET: begin
          state_ff <= ST_DIV;
        end
        ST_DIV: begin
          if (div_cnt_ff == 5'h1F) begin
            state_ff <= ST_DONE;
          end
        end
        ST_DONE: begin
          per_cnt_ff <= per_hit ? PER_RST : per_cnt_ff + 16'h0001;
          state_ff <= ST_IDLE;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // Compensation word is written once its last bit has been decided.
  assign mif.we = (state_ff == ST_WAIT) && CONV_DONE_I && comp_ff && last_bit;
  assign mif.waddr = sidx;
  assign mif.wdata = trial_kept;
  assign mif.raddr = sidx;

  // Raw ticks and their average; averages restart after new compensation values.
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      for (int i = 0; i < N_IN; i++) begin
        ticks_ff[i] <= TICK_RST;
        avg_ff[i] <= TICK_RST;
      end
    end else if (state_ff == ST_FIND && !in_range && comp_ff) begin
      for (int i = 0; i < N_IN; i++) begin
        avg_ff[i] <= TICK_RST;
      end
    end else if (state_ff == ST_WAIT && CONV_DONE_I && !comp_ff) begin
      ticks_ff[sidx] <= CONV_TICKS_I;
      avg_ff[sidx] <= avg_next;
    end
  end

  // Per input decisions and wheel sums, one input per cycle.
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      on_ff <= '0;
      wsum_ff <= '0;
      psum_ff <= '0;
      k_ff <= '0;
    end else if (state_ff == ST_FIND && !in_range) begin
      wsum_ff <= '0;
      psum_ff <= '0;
      k_ff <= '0;
    end else if (state_ff == ST_ACC && in_range) begin
      on_ff[sidx] <= cur_en && on_next(on_ff[sidx], cur_tick, cur_thr, HYST_I);
      if (cur_whl) begin
        k_ff <= k_ff + 4'h1;
        if (cur_pos) begin
          wsum_ff <= wsum_ff + 24'(cur_tick);
          psum_ff <= psum_ff + 24'(cur_tick * k_ff);
        end
      end
    end
  end

  // Quotient of weighted sum over sum, scaled to the configured maximum.
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      quo_ff <= '0;
      rem_ff <= '0;
      den_ff <= '0;
      div_cnt_ff <= '0;
    end else if (state_ff == ST_DSET) begin
      div_cnt_ff <= '0;
      rem_ff <= '0;
      if (k_ff < 4'h2 || wsum_ff == '0) begin
        quo_ff <= '0;
        den_ff <= '1;
      end else begin
        quo_ff <= DIV_W'(psum_ff * WHL_MAX_I);
        den_ff <= DIV_W'(wsum_ff * (k_ff - 4'h1));
      end
    end else if (state_ff == ST_DIV) begin
      rem_ff <= rem_nx;
      quo_ff <= {quo_ff[DIV_W-2:0], div_ge};
      div_cnt_ff <= div_cnt_ff + 5'h01;
    end
  end

  // Published results change only at the end of processing.
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      btn_ff <= '0;
      whl_on_ff <= 1'b0;
      pos_ff <= POS_RST;
      prev_ff <= POS_RST;
      prev_vld_ff <= 1'b0;
      cw_ff <= 1'b0;
      ccw_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= state_ff == ST_DONE;
      if (state_ff == ST_FIND && !in_range && comp_ff) begin
        prev_vld_ff <= 1'b0;
      end else if (state_ff == ST_DONE) begin
        btn_ff <= on_ff & EN_I & ~WHEEL_I;
        whl_on_ff <= any_whl_on;
        if (any_whl_on) begin
          pos_ff <= quo_pos;
          prev_ff <= quo_pos;
          prev_vld_ff <= 1'b1;
          cw_ff <= prev_vld_ff && !fwd[POS_W] && fwd[POS_W-1:0] >= STEP_I;
          ccw_ff <= prev_vld_ff && !bwd[POS_W] && bwd[POS_W-1:0] >= STEP_I;
        end else begin
          prev_vld_ff <= 1'b0;
          cw_ff <= 1'b0;
          ccw_ff <= 1'b0;
        end
      end
    end
  end

  // Every output is a flip-flop.
  assign CONV_START_O = start_ff;
  assign CONV_SEL_O = idx_ff;
  assign CONV_SENS_O = sens_ff;
  assign CONV_COMP_O = trial_ff;
  assign BTN_ON_O = btn_ff;
  assign WHL_ON_O = whl_on_ff;
  assign WHL_POS_O = pos_ff;
  assign ROT_CW_O = cw_ff;
  assign ROT_CCW_O = ccw_ff;
  assign COMP_BUSY_O = comp_ff;
  assign SCAN_DONE_O = done_ff;

endmodule : tcwd_top

// file: tb/tcwd_top_props.sv
// Port-level properties for the touch wheel block.
// Assumes one clock and the block's synchronous active-low reset.
`timescale 1ns/1ps
module tcwd_props import tcwd_pkg::*; #(
  parameter int N_IN = IN_NUM,
  parameter int SCAN_CYC = SCAN_CYC_DEF
) (
  // Clock, reset and configuration.
  input wire logic MCLK_I,
  input wire logic RESETN_I,
  input wire logic [N_IN-1:0] EN_I,
  input wire logic [N_IN-1:0] WHEEL_I,
  input wire logic [N_IN*SENS_W-1:0] SENS_I,
  input wire logic [POS_W-1:0] WHL_MAX_I,
  input wire logic [POS_W-1:0] STEP_I,
  // Block outputs.
  input wire logic CONV_START_O,
  input wire logic [IDX_W-1:0] CONV_SEL_O,
  input wire logic [SENS_W-1:0] CONV_SENS_O,
  input wire logic [N_IN-1:0] BTN_ON_O,
  input wire logic WHL_ON_O,
  input wire logic [POS_W-1:0] WHL_POS_O,
  input wire logic ROT_CW_O,
  input wire logic ROT_CCW_O,
  input wire logic COMP_BUSY_O,
  input wire logic SCAN_DONE_O
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RESETN_I);
  logic seen_ff;
  logic [IDX_W-1:0] last_ff;
  logic [POS_W-1:0] pos_ff;
  int gap_ff;
  // Last scan index, last result position and spacing between results.
  always_ff @(posedge MCLK_I) begin
    seen_ff <= RESETN_I && !SCAN_DONE_O && !COMP_BUSY_O && (seen_ff || CONV_START_O);
    last_ff <= CONV_START_O ? CONV_SEL_O : last_ff;
    pos_ff <= !RESETN_I ? POS_RST : (SCAN_DONE_O ? WHL_POS_O : pos_ff);
    gap_ff <= !RESETN_I ? SCAN_CYC : (SCAN_DONE_O ? 1 : gap_ff + 1);
  end
  a_sens_per_input: assert property (CONV_START_O |->
    CONV_SENS_O == SENS_I[CONV_SEL_O*SENS_W +: SENS_W]) else $error("sens mismatch");
  a_only_enabled: assert property (CONV_START_O |-> EN_I[CONV_SEL_O])
    else $error("disabled input measured");
  a_sel_held: assert property (CONV_START_O |=> $stable(CONV_SEL_O) [*2])
    else $error("select moved");
  a_scan_ascend: assert property (CONV_START_O && !COMP_BUSY_O && seen_ff |->
    CONV_SEL_O > last_ff) else $error("scan order");
  a_update_at_done: assert property ($changed(BTN_ON_O) || $changed(WHL_POS_O) |->
    SCAN_DONE_O) else $error("update off result");
  a_one_per_period: assert property (SCAN_DONE_O |-> gap_ff >= SCAN_CYC / 2)
    else $error("results too close");
  a_btn_masked: assert property ((BTN_ON_O & (WHEEL_I | ~EN_I)) == '0)
    else $error("masked button on");
  a_pos_range: assert property (WHL_POS_O <= WHL_MAX_I) else $error("position range");
  a_rot_cw_step: assert property (SCAN_DONE_O && ROT_CW_O |->
    {1'b0, WHL_POS_O} >= {1'b0, pos_ff} + STEP_I) else $error("cw step");
  a_rot_ccw_step: assert property (SCAN_DONE_O && ROT_CCW_O |->
    {1'b0, pos_ff} >= {1'b0, WHL_POS_O} + STEP_I) else $error("ccw step");
  a_rot_wheel_on: assert property (ROT_CW_O || ROT_CCW_O |-> WHL_ON_O && !(ROT_CW_O && ROT_CCW_O))
    else $error("rotation while off");
  a_hold_in_comp: assert property (COMP_BUSY_O && $past(COMP_BUSY_O) |->
    $stable(BTN_ON_O) && !SCAN_DONE_O) else $error("change during comp");
endmodule : tcwd_props

bind tcwd_top tcwd_props #(.N_IN(N_IN), .SCAN_CYC(SCAN_CYC)) props_u (
  .MCLK_I(MCLK_I), .RESETN_I(RESETN_I), .EN_I(EN_I), .WHEEL_I(WHEEL_I), .SENS_I(SENS_I),
  .WHL_MAX_I(WHL_MAX_I), .STEP_I(STEP_I), .CONV_START_O(CONV_START_O),
  .CONV_SEL_O(CONV_SEL_O), .CONV_SENS_O(CONV_SENS_O), .BTN_ON_O(BTN_ON_O),
  .WHL_ON_O(WHL_ON_O), .WHL_POS_O(WHL_POS_O), .ROT_CW_O(ROT_CW_O), .ROT_CCW_O(ROT_CCW_O),
  .COMP_BUSY_O(COMP_BUSY_O), .SCAN_DONE_O(SCAN_DONE_O));

// file: tb/tcwd_conv_model.sv
// Behavioural tick converter with its sense electrodes.
// Assumes select and compensation are held from start until the answer.
`timescale 1ns/1ps
module tcwd_conv_model import tcwd_pkg::*; (
  // Link from the block.
  input wire logic clk_i,
  input wire logic start_i,
  input wire logic [IDX_W-1:0] sel_i,
  input wire logic [COMP_W-1:0] comp_i,
  input wire logic [IN_NUM*TICK_W-1:0] touch_i,
  // Answer.
  output logic done_o,
  output logic [TICK_W-1:0] ticks_o
);
  int wait_q = 0;
  int turn_q = 0;
  logic [TICK_W-1:0] res_q = 16'h0000;
  initial begin
    done_o = 1'b0;
    ticks_o = 16'h0000;
  end
  // Load less compensation plus finger; delay cycles 1 to 4 so slow replies occur too.
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    ticks_o <= ~ticks_o; // Not valid outside an answer, so it keeps changing.
    if (start_i) begin
      turn_q <= (turn_q + 1) % 4;
      wait_q <= turn_q + 1;
      res_q <= 16'h1000 + {4'h0, sel_i, 8'h00} - comp_i + touch_i[sel_i*TICK_W +: TICK_W];
    end else if (wait_q > 0) begin
      wait_q <= wait_q - 1;
      if (wait_q == 1) begin
        done_o <= 1'b1;
        ticks_o <= res_q;
      end
    end
  end
endmodule : tcwd_conv_model

// file: tb/touch_wheel_detect_compensation_bench.sv
// Self-checking bench: reference model of detection, wheel and compensation.
// Assumes a 400-clock scan period and the converter model above.
`timescale 1ns/1ps
module touch_wheel_detect_compensation_bench import tcwd_pkg::*; ;
  localparam int SC = 400;
  logic mclk = 1'b0, rstn = 1'b0, run = 1'b0, creq = 1'b0;
  logic [11:0] en = 12'hFEF, whl = 12'hFC0, btn;
  logic [191:0] thr, touch = '0;
  logic [47:0] sens;
  logic [15:0] hy = 16'h0020, npos = 16'h7FFF, nneg = 16'h7FFF, cper = 16'h0000, ccomp, ctk;
  logic [7:0] wmax = 8'hC8, step = 8'h10, wpos;
  logic [3:0] csel;
  logic cst, cdone, won, rcw, rccw, busy, sdone;
  int fail_count = 0, compares = 0, nconv = 0, ppos = 0, pok = 0, epos = 0, nbad = 0;
  int on_q[12] = '{default: 0};
  int hv[3] = '{16'h011F, 16'h00DF, 16'h00DE};

  tcwd_top #(.SCAN_CYC(SC)) dut_u (.MCLK_I(mclk), .RESETN_I(rstn), .RUN_I(run),
    .COMP_REQ_I(creq), .EN_I(en), .WHEEL_I(whl), .THRESH_I(thr), .HYST_I(hy), .SENS_I(sens),
    .WHL_MAX_I(wmax), .STEP_I(step), .NOISE_POS_I(npos), .NOISE_NEG_I(nneg),
    .COMP_PERIOD_I(cper), .CONV_START_O(cst), .CONV_SEL_O(csel), .CONV_SENS_O(),
    .CONV_COMP_O(ccomp), .CONV_DONE_I(cdone), .CONV_TICKS_I(ctk), .BTN_ON_O(btn),
    .WHL_ON_O(won), .WHL_POS_O(wpos), .ROT_CW_O(rcw), .ROT_CCW_O(rccw), .COMP_BUSY_O(busy),
    .SCAN_DONE_O(sdone));
  tcwd_conv_model conv_u (.clk_i(mclk), .start_i(cst), .sel_i(csel), .comp_i(ccomp),
    .touch_i(touch), .done_o(cdone), .ticks_o(ctk));

  // Free-running 200 MHz clock.
  always #2.5 mclk = ~mclk;

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_bits(input logic [11:0] got, input logic [11:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected bits at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_bits

  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize

  // Bounded wait for a result (0), busy high (1) or busy low (2); a timeout ends the run.
  task automatic wait_sig(input int which, input int lim);
    int n;
    logic hit;
    n = 0;
    hit = 1'b0;
    while (n < lim && !hit) begin
      @(negedge mclk);
      n++;
      hit = (which == 0 ? sdone : (which == 1 ? busy : !busy)) === 1'b1;
    end
    // A wait that runs out is a failure in itself, whatever the count shows.
    if (!hit) begin
      fail_count++;
      $display("unexpected timeout at %0t: got %h expected below %h", $time, n, lim);
      summarize();
    end
  endtask : wait_sig

  // Scan conversions must use the word a compensation run settles on: load minus one.
  always @(negedge mclk) begin
    if (!rstn) nconv = 0;
    else if (sdone) begin
      chk_val(16'(nconv), 16'h000B);
      nconv = 0;
    end else if (cst && !busy) begin
      nconv++;
      chk_val(ccomp, 16'h0FFF + {csel, 8'h00});
    end
  end

  // Reference for one scan: hysteresis per input, wheel centroid and rotation.
  task automatic scan_check();
    int t, sw, s, k, p;
    logic [11:0] eb;
    logic [2:0] ef;
    eb = '0;
    ef = '0;
    sw = 0;
    s = 0;
    k = 0;
    p = epos;
    wait_sig(0, 3 * SC);
    for (int i = 0; i < 12; i++) begin
      if (!en[i]) continue;
      t = touch[i*16 +: 16] + 1;
      if (t >= thr[i*16 +: 16] + hy) on_q[i] = 1;
      else if (t < thr[i*16 +: 16] - hy) on_q[i] = 0;
      if (whl[i]) begin
        ef[2] = ef[2] | (on_q[i] != 0);
        sw += t * k;
        s += t;
        k++;
      end else eb[i] = (on_q[i] != 0);
    end
    if (ef[2]) begin
      p = sw * wmax / (s * (k - 1));
      p = (p > wmax) ? wmax : p;
      ef[1] = pok != 0 && p - ppos >= int'(step);
      ef[0] = pok != 0 && ppos - p >= int'(step);
    end
    ppos = p;
    epos = p;
    pok = ef[2];
    chk_bits(btn, eb);
    chk_bits({9'h000, won, rcw, rccw}, {9'h000, ef});
    chk_val({8'h00, wpos}, 16'(epos));
  endtask : scan_check

  // Main sequence, all inputs changed at the falling edge.
  initial begin
    void'($urandom(58));
    for (int i = 0; i < 12; i++) thr[i*16 +: 16] = 16'h0100 + 16'(i * 16);
    thr[80 +: 16] = 16'h0400; // Proximity input: same rule, higher threshold.
    sens = {16'($urandom), $urandom};
    repeat (20) @(negedge mclk);
    rstn = 1'b1;
    run = 1'b1;
    wait_sig(1, 3 * SC);
    wait_sig(2, 4000);
    foreach (hv[j]) begin
      touch[0 +: 16] = 16'(hv[j]);
      scan_check();
    end
    for (int r = 0; r < 30; r++) begin
      int c;
      touch = '0;
      for (int i = 0; i < 6; i++) touch[i*16 +: 16] = 16'($urandom_range(0, 16'h0480));
      c = $urandom_range(0, 7);
      if (c < 6) touch[(6 + c)*16 +: 16] = 16'($urandom_range(16'h0200, 16'h0400));
      if (c < 5) touch[(7 + c)*16 +: 16] = 16'($urandom_range(0, 16'h0200));
      scan_check();
    end
    // A mid-run reset clears results; compensation is estimated afresh.
    touch = '0;
    rstn = 1'b0;
    repeat (20) @(negedge mclk);
    chk_bits(btn, 12'h000);
    rstn = 1'b1;
    on_q = '{default: 0};
    pok = 0;
    epos = 0;
    wait_sig(1, 3 * SC);
    wait_sig(2, 4000);
    scan_check();
    // Host request after a sensitivity change, then periodic and noise-band triggers.
    sens = {16'($urandom), $urandom};
    creq = 1'b1;
    @(negedge mclk);
    creq = 1'b0;
    wait_sig(1, 3 * SC);
    wait_sig(2, 4000);
    // Sleep: no scan runs and a host request is ignored.
    run = 1'b0;
    creq = 1'b1;
    repeat (2 * SC) begin
      @(negedge mclk);
      creq = 1'b0;
      if (busy !== 1'b0 || sdone !== 1'b0) nbad++;
    end
    chk_val(16'(nbad), 16'h0000);
    run = 1'b1;
    pok = 0;
    touch[96 +: 16] = 16'h0300;
    scan_check();
    touch = '0;
    scan_check();
    cper = 16'h0003;
    wait_sig(1, 6 * SC);
    cper = 16'h0000;
    wait_sig(2, 4000);
    npos = 16'h0008;
    touch[0 +: 16] = 16'h0040;
    wait_sig(1, 5 * SC);
    summarize();
  end
endmodule : touch_wheel_detect_compensation_bench
